// *** dv/host_model.sv ***
// host processor model writing control words over the parallel bus
`timescale 1ns/1ns
module host_model
    import nco_pkg::*;
(
    input wire logic mclk_i, // clock
    output logic [CTRL_W-1:0] word_o, // control word bus
    output logic [1:0] sel_o, // register address
    output logic cs_n_o, // chip select
    output logic wr_n_o // write strobe
);
    // idle bus at time zero
    initial begin
        word_o = 16'h0000;
        sel_o = 2'h0;
        cs_n_o = 1'b1;
        wr_n_o = 1'b1;
    end

    // one write, held through the capture edge, then released
    task automatic write_word(input logic [1:0] sel, input logic [CTRL_W-1:0] data,
                              input logic cs_n);
        @(posedge mclk_i);
        word_o <= data;
        sel_o <= sel;
        cs_n_o <= cs_n;
        wr_n_o <= 1'b0;
        @(posedge mclk_i);
        cs_n_o <= 1'b1;
        wr_n_o <= 1'b1;
        word_o <= ~data; // released bus must not show a stale word
    endtask
endmodule

// *** dv/nco_phase_and_sincos_asserts.sv ***
// assertion checker for the oscillator phase and sine/cosine block
`timescale 1ns/1ns
module nco_phase_and_sincos_asserts
    import nco_pkg::*;
(
    input wire logic mclk_i, // clock
    input wire logic rst_n_i, // reset
    input wire logic [CTRL_W-1:0] control_word_bus_i, // bus
    input wire logic [1:0] reg_select_i, // address
    input wire logic cs_n_i, // select
    input wire logic wr_n_i, // write
    input wire logic center_freq_load_en_n_i, // center en
    input wire logic offset_freq_load_en_n_i, // offset en
    input wire logic timer_step_load_en_n_i, // timer en
    input wire logic phase_load_en_n_i, // phase en
    input wire logic phase_source_sel_i, // source
    input wire logic [1:0] qpsk_symbol_i, // symbol
    input wire logic offset_freq_disable_n_i, // offset off
    input wire logic accum_init_n_i, // acc init
    input wire logic timer_init_bypass_n_i, // bypass
    input wire logic phase_range_sel_i, // range
    input wire logic phase_carry_n_o, // phase carry
    input wire logic timer_carry_n_o, // timer carry
    input wire logic [ACC_W-1:0] phase_arg_o, // argument
    input wire logic [TRIG_W-1:0] real_out_low_o, // real
    input wire logic [TRIG_W-1:0] imag_out_low_o // imag
);
    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    logic [2:0] quiet_q;
    logic [1:0] up_q;
    // no load, init or range change: the argument must step evenly
    wire quiet = center_freq_load_en_n_i & offset_freq_load_en_n_i & phase_load_en_n_i &
        accum_init_n_i & offset_freq_disable_n_i & !phase_range_sel_i;
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            quiet_q <= 3'h0;
            up_q <= 2'h0;
        end else begin
            quiet_q <= !quiet ? 3'h0 : (quiet_q == 3'h7 ? quiet_q : quiet_q + 3'h1);
            up_q <= (up_q == 2'h3) ? up_q : up_q + 2'h1;
        end
    end

    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    arg_step_a: assert property (quiet_q >= 3'h6 |->
        (phase_arg_o - $past(phase_arg_o)) == ($past(phase_arg_o) - $past(phase_arg_o, 2)))
        else $error("argument step not constant");
    range_msb_a: assert property (phase_range_sel_i |=> !phase_arg_o[31])
        else $error("modulo pi argument has msb set");
    trig_range_a: assert property (timer_init_bypass_n_i |=>
        real_out_low_o != 16'h8000 && imag_out_low_o != 16'h8000)
        else $error("sine or cosine hit 8000");
    timer_stop_a: assert property (!timer_init_bypass_n_i |=> !timer_carry_n_o)
        else $error("timer carry while feedback zeroed");
    phase_init_a: assert property (!accum_init_n_i |=> phase_carry_n_o)
        else $error("phase carry while feedback zeroed");
    bypass_route_a: assert property (!timer_init_bypass_n_i |=>
        {imag_out_low_o, real_out_low_o} == $past(phase_arg_o))
        else $error("bypass output differs from argument");
    reset_state_a: assert property ($rose(rst_n_i) |->
        phase_carry_n_o && !timer_carry_n_o && phase_arg_o == 32'h0000_0000)
        else $error("outputs not at reset state");
    trig_steady_a: assert property (up_q == 2'h3 && $stable(phase_arg_o) &&
        timer_init_bypass_n_i && $past(timer_init_bypass_n_i) |=>
        $stable(real_out_low_o) && $stable(imag_out_low_o))
        else $error("sine/cosine moved with argument fixed");

    // main scenarios reached
    cover property (!timer_init_bypass_n_i);
    cover property (!phase_carry_n_o);
    cover property (timer_carry_n_o);
endmodule

bind nco_phase_and_sincos nco_phase_and_sincos_asserts u_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .control_word_bus_i(control_word_bus_i),
    .reg_select_i(reg_select_i), .cs_n_i(cs_n_i), .wr_n_i(wr_n_i),
    .center_freq_load_en_n_i(center_freq_load_en_n_i),
    .offset_freq_load_en_n_i(offset_freq_load_en_n_i),
    .timer_step_load_en_n_i(timer_step_load_en_n_i), .phase_load_en_n_i(phase_load_en_n_i),
    .phase_source_sel_i(phase_source_sel_i), .qpsk_symbol_i(qpsk_symbol_i),
    .offset_freq_disable_n_i(offset_freq_disable_n_i), .accum_init_n_i(accum_init_n_i),
    .timer_init_bypass_n_i(timer_init_bypass_n_i), .phase_range_sel_i(phase_range_sel_i),
    .phase_carry_n_o(phase_carry_n_o), .timer_carry_n_o(timer_carry_n_o),
    .phase_arg_o(phase_arg_o), .real_out_low_o(real_out_low_o),
    .imag_out_low_o(imag_out_low_o));

// *** dv/tb_top.sv ***
// self-checking bench for the oscillator phase and sine/cosine block
`timescale 1ns/1ns
module tb_top
    import nco_pkg::*;
;
    typedef struct {logic src; logic [1:0] sym; logic [15:0] word; logic rng;
        logic [15:0] hi; logic [15:0] cs; logic [15:0] sn; logic trig;} row_s;
    logic mclk_i, rst_n, cf_en_n, of_en_n, ts_en_n, ph_en_n, src_sel, of_dis_n;
    logic acc_init_n, byp_n, rng, pc_n, tc_n, cs_n, wr_n;
    logic [1:0] sym, sel;
    logic [15:0] bus, re, im;
    logic [31:0] arg, n;
    int n_mismatch = 0;
    int samples_checked = 0;
    row_s rows [6] = '{
        '{1'b0, 2'h0, 16'h0000, 1'b0, 16'h0000, 16'h7FFF, 16'h0000, 1'b1},
        '{1'b0, 2'h1, 16'h0000, 1'b0, 16'h4000, 16'h0000, 16'h7FFF, 1'b1},
        '{1'b0, 2'h2, 16'h0000, 1'b0, 16'hC000, 16'h0000, 16'h8001, 1'b1},
        '{1'b0, 2'h3, 16'h0000, 1'b0, 16'h8000, 16'h8001, 16'h0000, 1'b1},
        '{1'b1, 2'h0, 16'h1234, 1'b0, 16'h1234, 16'h0000, 16'h0000, 1'b0},
        '{1'b1, 2'h0, 16'hC000, 1'b1, 16'h4000, 16'h0000, 16'h7FFF, 1'b1}};

    host_model host (.mclk_i(mclk_i), .word_o(bus), .sel_o(sel), .cs_n_o(cs_n), .wr_n_o(wr_n));
    nco_phase_and_sincos DUT (.mclk_i(mclk_i), .rst_n_i(rst_n), .control_word_bus_i(bus),
        .reg_select_i(sel), .cs_n_i(cs_n), .wr_n_i(wr_n), .center_freq_load_en_n_i(cf_en_n),
        .offset_freq_load_en_n_i(of_en_n), .timer_step_load_en_n_i(ts_en_n),
        .phase_load_en_n_i(ph_en_n), .phase_source_sel_i(src_sel), .qpsk_symbol_i(sym),
        .offset_freq_disable_n_i(of_dis_n), .accum_init_n_i(acc_init_n),
        .timer_init_bypass_n_i(byp_n), .phase_range_sel_i(rng), .phase_carry_n_o(pc_n),
        .timer_carry_n_o(tc_n), .phase_arg_o(arg), .real_out_low_o(re), .imag_out_low_o(im));

    // ------------------------------------------------------------
    // helper tasks
    // ------------------------------------------------------------
    task automatic tick(input int c);
        repeat (c) @(posedge mclk_i);
    endtask
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // lookup outputs are approximate, so allow a few lsb
    task automatic check_near(input logic [15:0] got, input logic [15:0] exp);
        logic signed [16:0] d;
        d = $signed({got[15], got}) - $signed({exp[15], exp});
        samples_checked++;
        if ((d <= 17'sh3 && d >= -17'sh3) !== 1'b1) begin
            n_mismatch++;
            $display("unexpected at %0t: trig %h want %h", $time, got, exp);
        end
    endtask
    // difference of the argument over one clock
    task automatic check_step(input logic [31:0] step);
        logic [31:0] a0;
        #1;
        a0 = arg;
        @(posedge mclk_i);
        #1;
        check_val(arg - a0, step);
        @(posedge mclk_i);
    endtask
    // count phase carry lows (t=0) or timer carry highs (t=1)
    task automatic count_hits(input bit t, input int c, output logic [31:0] k);
        k = 32'h0;
        repeat (c) begin
            @(posedge mclk_i);
            #1;
            if (t ? tc_n === 1'b1 : pc_n === 1'b0) k++;
        end
        @(posedge mclk_i);
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end
    initial begin
        tick(20000);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        {rst_n, src_sel, rng, sym} = 5'h00;
        {cf_en_n, of_en_n, ts_en_n, ph_en_n, of_dis_n, acc_init_n, byp_n} = 7'h7F;
        tick(8);
        rst_n <= 1'b1;
        #1;
        check_val({30'h0, pc_n, tc_n}, 32'h2);
        tick(1);
        ph_en_n <= 1'b0;
        // table rows: phase source, symbol codes, range and lookup
        for (int i = 0; i < 6; i++) begin
            src_sel <= rows[i].src;
            sym <= rows[i].sym;
            rng <= rows[i].rng;
            if (rows[i].src) host.write_word(SEL_PHASE, rows[i].word, 1'b0);
            tick(6);
            #1;
            check_val(arg, {rows[i].hi, 16'h0000});
            if (rows[i].trig) check_near(re, rows[i].cs);
            if (rows[i].trig) check_near(im, rows[i].sn);
            tick(1);
        end
        host.write_word(SEL_PHASE, 16'h0000, 1'b0);
        rng <= 1'b0;
        tick(3);
        ph_en_n <= 1'b1;
        // frequency words, with writes that must be ignored in between
        host.write_word(SEL_FREQ_LOW, 16'h0000, 1'b0);
        host.write_word(SEL_FREQ_HIGH, 16'h4000, 1'b0);
        host.write_word(2'h3, 16'hFFFF, 1'b0);
        host.write_word(SEL_FREQ_HIGH, 16'h1234, 1'b1);
        cf_en_n <= 1'b0;
        tick(1);
        cf_en_n <= 1'b1;
        host.write_word(SEL_FREQ_HIGH, 16'h2000, 1'b0);
        of_en_n <= 1'b0;
        tick(1);
        of_en_n <= 1'b1;
        tick(6);
        check_step(32'h6000_0000);
        count_hits(1'b0, 16, n);
        check_val(n, 32'h6);
        of_dis_n <= 1'b0;
        tick(4);
        check_step(32'h4000_0000);
        of_dis_n <= 1'b1;
        tick(4);
        check_step(32'h6000_0000);
        acc_init_n <= 1'b0;
        tick(3);
        check_step(32'h0000_0000);
        #1;
        check_val(arg, 32'h6000_0000);
        tick(1);
        acc_init_n <= 1'b1;
        // timer step and carry, then bypass
        host.write_word(SEL_FREQ_HIGH, 16'h4000, 1'b0);
        ts_en_n <= 1'b0;
        tick(1);
        ts_en_n <= 1'b1;
        tick(4);
        count_hits(1'b1, 16, n);
        check_val(n, 32'h4);
        byp_n <= 1'b0;
        tick(3);
        #1;
        check_val({im, re}, arg - 32'h6000_0000);
        count_hits(1'b1, 8, n);
        check_val(n, 32'h0);
        byp_n <= 1'b1;
        tick(2);
        print_verdict();
    end
endmodule

// *** verilog/nco_accum.sv ***
// 32-bit step accumulator with feedback gate and registered carry
`timescale 1ns/1ns
module nco_accum
    import nco_pkg::*;
#(
    parameter bit INVERT_CARRY = 1'b0
) (
    input wire logic mclk_i, // system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic [ACC_W-1:0] step_i, // amount added each clock
    input wire logic feedback_en_i, // low zeroes the feedback path
    output logic [ACC_W-1:0] sum_o, // accumulator register
    output logic carry_o // registered adder overflow
);

    // ------------------------------------------------------------
    // adder
    // ------------------------------------------------------------
    // wrapped sum kept, the extra bit is the overflow
    logic [ACC_W-1:0] feedback_w;
    logic [ACC_W:0] sum_w;
    assign feedback_w = feedback_en_i ? sum_o : ACC_RST;
    assign sum_w = {1'b0, feedback_w} + {1'b0, step_i};

    // ------------------------------------------------------------
    // register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sum_o <= ACC_RST;
            carry_o <= INVERT_CARRY;
        end else begin
            sum_o <= sum_w[ACC_W-1:0];
            carry_o <= sum_w[ACC_W] ^ INVERT_CARRY;
        end
    end

endmodule

// *** verilog/nco_phase_and_sincos.sv ***
// phase/frequency control section and sine/cosine generator of the oscillator
//
// Overview of operation
// - each accumulator adds its 32-bit step every clock, wraps, outputs overflow
// - phase step is center plus offset frequency, modulo 2^32, signed
// - phase carry output is the inverted phase adder overflow
// - timer carry output is the time adder overflow, its only output
// - host writes 16-bit words while chip select and write are low
// - address 0 low freq, 1 high freq, 2 phase, 3 reserved
// - high and low input words form the 32-bit frequency load source
// - low load enable registered first, target reloads each cycle it stays low
// - source select high: phase register loads phase input when enabled
// - source select low: symbol bits form phase MSBs, lower 14 bits zero
// - symbol 00, 01, 10, 11 give 0, 90, 270, 180 degrees
// - phase register adds to upper 16 accumulator bits, forming argument
// - offset disable low zeroes offset contribution, keeps register contents
// - accumulator init low zeroes phase feedback, loads current step
// - range select picks argument span 0-180 or 0-360 degrees
// - timer step loads from input words while its enable is low
// - timer init/bypass low zeroes timer feedback, stopping its carry
// - top 20 argument bits produce 16-bit sine and cosine
// - lookup address maps linearly onto one counterclockwise turn
// - sine and cosine are symmetric, 8001 to 7FFF, never 8000
// - vector error magnitude below -90.2 dB full scale
// - bypass low routes argument to outputs, upper on imag, lower on real
`timescale 1ns/1ns
module nco_phase_and_sincos
    import nco_pkg::*;
(
    input wire logic mclk_i, // 10 MHz system clock
    input wire logic rst_n_i, // async reset, active low
    input wire logic [CTRL_W-1:0] control_word_bus_i, // host control word
    input wire logic [1:0] reg_select_i, // input register address
    input wire logic cs_n_i, // chip select, active low
    input wire logic wr_n_i, // write strobe, active low
    input wire logic center_freq_load_en_n_i, // center freq load enable
    input wire logic offset_freq_load_en_n_i, // offset freq load enable
    input wire logic timer_step_load_en_n_i, // timer step load enable
    input wire logic phase_load_en_n_i, // phase register load enable
    input wire logic phase_source_sel_i, // 1 phase input, 0 qpsk symbol
    input wire logic [1:0] qpsk_symbol_i, // modulation code, bit 1 MSB
    input wire logic offset_freq_disable_n_i, // low removes the offset
    input wire logic accum_init_n_i, // low zeroes phase feedback
    input wire logic timer_init_bypass_n_i, // low zeroes timer, bypasses lookup
    input wire logic phase_range_sel_i, // 1 modulo pi, 0 modulo 2 pi
    output logic phase_carry_n_o, // inverted phase overflow
    output logic timer_carry_n_o, // timer overflow
    output logic [ACC_W-1:0] phase_arg_o, // sine/cosine argument
    output logic [TRIG_W-1:0] real_out_low_o, // cosine or argument low half
    output logic [TRIG_W-1:0] imag_out_low_o // sine or argument high half
);

    // ------------------------------------------------------------
    // host input registers
    // ------------------------------------------------------------
    logic [CTRL_W-1:0] freq_low_q;
    logic [CTRL_W-1:0] freq_high_q;
    logic [CTRL_W-1:0] phase_in_q;
    logic write_w;
    logic wr_low_w;
    logic wr_high_w;
    logic wr_phase_w;

    // both strobes low take the word; address 3 and cs high do nothing
    // capture is level, no strobe edge needed
    assign write_w = !cs_n_i && !wr_n_i;
    assign wr_low_w = write_w && (reg_select_i == SEL_FREQ_LOW);
    assign wr_high_w = write_w && (reg_select_i == SEL_FREQ_HIGH);
    assign wr_phase_w = write_w && (reg_select_i == SEL_PHASE);

    // level-sensitive capture: the word follows the bus each cycle held
    // a held write keeps the last word seen
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            freq_low_q <= WORD_RST;
            freq_high_q <= WORD_RST;
            phase_in_q <= WORD_RST;
        end else begin
            if (wr_low_w) begin
                freq_low_q <= control_word_bus_i;
            end
            if (wr_high_w) begin
                freq_high_q <= control_word_bus_i;
            end
            if (wr_phase_w) begin
                phase_in_q <= control_word_bus_i;
            end
        end
    end

    // ------------------------------------------------------------
    // registered load enables
    // ------------------------------------------------------------
    // one-cycle delay so the host can set data and enable together
    // reset leaves all targets unloaded
    logic center_freq_load_en_q;
    logic offset_freq_load_en_q;
    logic timer_step_load_en_q;
    logic phase_load_en_q;

    // targets see an enable one edge later
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            center_freq_load_en_q <= EN_N_RST;
            offset_freq_load_en_q <= EN_N_RST;
            timer_step_load_en_q <= EN_N_RST;
            phase_load_en_q <= EN_N_RST;
        end else begin
            center_freq_load_en_q <= center_freq_load_en_n_i;
            offset_freq_load_en_q <= offset_freq_load_en_n_i;
            timer_step_load_en_q <= timer_step_load_en_n_i;
            phase_load_en_q <= phase_load_en_n_i;
        end
    end

    // ------------------------------------------------------------
    // frequency and timer step registers
    // ------------------------------------------------------------
    logic [ACC_W-1:0] freq_word_w;
    logic [ACC_W-1:0] center_freq_q;
    logic [ACC_W-1:0] offset_freq_q;
    logic [ACC_W-1:0] timer_step_q;

    assign freq_word_w = {freq_high_q, freq_low_q};

    // reload every cycle while the registered enable stays low
    // change the words before enabling, not during
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            center_freq_q <= ACC_RST;
            offset_freq_q <= ACC_RST;
            timer_step_q <= ACC_RST;
        end else begin
            if (!center_freq_load_en_q) begin
                center_freq_q <= freq_word_w;
            end
            if (!offset_freq_load_en_q) begin
                offset_freq_q <= freq_word_w;
            end
            if (!timer_step_load_en_q) begin
                timer_step_q <= freq_word_w;
            end
        end
    end

    // ------------------------------------------------------------
    // phase register
    // ------------------------------------------------------------
    // symbol code is gray-ordered so 10 lands on 270 and 11 on 180
    // plain bit split would swap 180 and 270
    logic [PHASE_W-1:0] qpsk_phase_w;
    logic [PHASE_W-1:0] phase_src_w;
    logic [PHASE_W-1:0] phase_q;

    assign qpsk_phase_w = {qpsk_symbol_i[1],
                           qpsk_symbol_i[1] ^ qpsk_symbol_i[0],
                           {QPSK_ZERO_W{1'b0}}};
    assign phase_src_w = phase_source_sel_i ? phase_in_q : qpsk_phase_w;

    // phase register holds while disabled
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_q <= WORD_RST;
        end else if (!phase_load_en_q) begin
            phase_q <= phase_src_w;
        end
    end

    // ------------------------------------------------------------
    // phase step and accumulators
    // ------------------------------------------------------------
    // offset gated, not cleared, so re-enabling restores the old value
    // sign of the step sets rotation direction
    logic [ACC_W-1:0] offset_used_w;
    logic [ACC_W-1:0] phase_step_w;
    logic [ACC_W-1:0] phase_acc_w;

    assign offset_used_w = offset_freq_disable_n_i ? offset_freq_q : ACC_RST;
    assign phase_step_w = center_freq_q + offset_used_w;

    // phase accumulator: carry comes out inverted
    // one carry pulse per wrap
    nco_accum #(
        .INVERT_CARRY(1'b1)
    ) u_phase_acc (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .step_i(phase_step_w),
        .feedback_en_i(accum_init_n_i),
        .sum_o(phase_acc_w),
        .carry_o(phase_carry_n_o)
    );

    // time accumulator: only its overflow leaves the block
    // gate shares the bypass pin
    nco_accum #(
        .INVERT_CARRY(1'b0)
    ) u_time_acc (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .step_i(timer_step_q),
        .feedback_en_i(timer_init_bypass_n_i),
        .sum_o(),
        .carry_o(timer_carry_n_o)
    );

    // ------------------------------------------------------------
    // phase adder and range
    // ------------------------------------------------------------
    logic [ACC_W-1:0] arg_sum_w;
    logic [ACC_W-1:0] arg_w;

    // phase word weights the top half only
    assign arg_sum_w = phase_acc_w + {phase_q, WORD_RST};
    // half-turn mode drops the top bit so the angle stays below pi
    assign arg_w = phase_range_sel_i ? {1'b0, arg_sum_w[ACC_W-2:0]}
                                     : arg_sum_w;

    // one cycle of latency buys a clean
    // path into the rotation engine
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_arg_o <= ACC_RST;
        end else begin
            phase_arg_o <= arg_w;
        end
    end

    // ------------------------------------------------------------
    // sine/cosine generator
    // ------------------------------------------------------------
    // rotation engine instead of a rom: 20 unrolled stages settle well
    // inside one 100 ns cycle and keep vector error below -90 dB
    logic [LUT_ADDR_W-1:0] lut_addr_w;
    logic [1:0] quadrant_w;
    logic signed [ROT_W-1:0] rot_x_w;
    logic signed [ROT_W-1:0] rot_y_w;
    logic [TRIG_W-1:0] base_cos_w;
    logic [TRIG_W-1:0] base_sin_w;
    logic [TRIG_W-1:0] cos_w;
    logic [TRIG_W-1:0] sin_w;

    assign lut_addr_w = phase_arg_o[ACC_W-1 -: LUT_ADDR_W];
    assign quadrant_w = lut_addr_w[LUT_ADDR_W-1 -: 2];

    // residual angle below a quarter turn, one turn = 2^26 units
    // top two bits pick the quadrant, folded
    // back later, so rotation stays 0..90
    always_comb begin
        logic signed [ROT_W-1:0] x;
        logic signed [ROT_W-1:0] y;
        logic signed [ROT_W-1:0] z;
        logic signed [ROT_W-1:0] xs;

        x = ROT_GAIN_X0;
        y = '0;
        z = '0;
        xs = '0;
        z[LUT_ADDR_W-2+ANGLE_EXT-1:0] = {lut_addr_w[LUT_ADDR_W-3:0],
                                         {ANGLE_EXT{1'b0}}};
        // each stage steers the residual to zero
        for (int i = 0; i < ROT_STAGES; i++) begin
            xs = x;
            if (!z[ROT_W-1]) begin
                x = x - (y >>> i);
                y = y + (xs >>> i);
                z = z - ROT_ATAN[i];
            end else begin
                x = x + (y >>> i);
                y = y - (xs >>> i);
                z = z + ROT_ATAN[i];
            end
        end

        rot_x_w = x;
        rot_y_w = y;
    end

    // round away the guard bits and pin to the symmetric range
    // clamping keeps 8000 out of sine and cosine, but bypass can still show it
    function automatic logic [TRIG_W-1:0] trig_sat(input logic signed [ROT_W-1:0] v);
        logic signed [ROT_W-1:0] r;

        r = (v + ROT_ROUND) >>> ROT_FRAC;
        if (r > TRIG_MAX) begin
            r = TRIG_MAX;
        end else if (r < -TRIG_MAX) begin
            r = -TRIG_MAX;
        end
        return r[TRIG_W-1:0];
    endfunction

    // error set by rounding, not by stages
    assign base_cos_w = trig_sat(rot_x_w);
    assign base_sin_w = trig_sat(rot_y_w);

    // quadrant fold; negating +-7FFF can never reach 8000
    // quadrant 0 passes, 2 negates both, 1 and 3 swap and negate one
    always_comb begin
        case (quadrant_w)
            2'h0: begin
                cos_w = base_cos_w;
                sin_w = base_sin_w;
            end
            2'h1: begin
                cos_w = -base_sin_w;
                sin_w = base_cos_w;
            end
            2'h2: begin
                cos_w = -base_cos_w;
                sin_w = -base_sin_w;
            end
            default: begin
                cos_w = base_sin_w;
                sin_w = -base_cos_w;
            end
        endcase
    end

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    // bypass shows the raw argument, upper half on the imaginary side
    // bypass pin acts on the next edge
    logic [TRIG_W-1:0] real_d;
    logic [TRIG_W-1:0] imag_d;

    assign real_d = timer_init_bypass_n_i ? cos_w : phase_arg_o[TRIG_W-1:0];
    assign imag_d = timer_init_bypass_n_i ? sin_w : phase_arg_o[ACC_W-1 -: TRIG_W];

    // outputs leave straight from flops
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            real_out_low_o <= WORD_RST;
            imag_out_low_o <= WORD_RST;
        end else begin
            real_out_low_o <= real_d;
            imag_out_low_o <= imag_d;
        end
    end

endmodule

// *** verilog/nco_pkg.sv ***
// shared constants for the oscillator phase/frequency section and sin/cos stage
package nco_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int CTRL_W = 16;
    localparam int ACC_W = 32;
    localparam int PHASE_W = 16;
    localparam int LUT_ADDR_W = 20;
    localparam int TRIG_W = 16;
    localparam int QPSK_ZERO_W = 14;

    // ------------------------------------------------------------
    // control word address codes
    // ------------------------------------------------------------
    localparam logic [1:0] SEL_FREQ_LOW = 2'h0;
    localparam logic [1:0] SEL_FREQ_HIGH = 2'h1;
    localparam logic [1:0] SEL_PHASE = 2'h2;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
    localparam logic [CTRL_W-1:0] WORD_RST = 16'h0000;
    localparam logic EN_N_RST = 1'b1;

    // ------------------------------------------------------------
    // rotation engine: 26-bit signed datapath, 8 guard bits
    // angle unit: one full turn is 2^26
    // ------------------------------------------------------------
    localparam int ROT_W = 26;
    localparam int ROT_STAGES = 20;
    localparam int ROT_FRAC = 8;
    localparam int ANGLE_EXT = 6;
    localparam logic signed [ROT_W-1:0] ROT_GAIN_X0 = 26'sh04D_B9C9;
    localparam logic signed [ROT_W-1:0] ROT_ROUND = 26'sh000_0080;
    localparam logic signed [ROT_W-1:0] TRIG_MAX = 26'sh000_7FFF;
    localparam logic signed [ROT_W-1:0] ROT_ATAN [ROT_STAGES] = '{
        26'sh080_0000, 26'sh04B_9044, 26'sh027_ED5E, 26'sh014_4487,
        26'sh00A_2C35, 26'sh005_175C, 26'sh002_8BD8, 26'sh001_45F2,
        26'sh000_A2F9, 26'sh000_517D, 26'sh000_28BE, 26'sh000_145F,
        26'sh000_0A30, 26'sh000_0518, 26'sh000_028C, 26'sh000_0146,
        26'sh000_00A3, 26'sh000_0051, 26'sh000_0029, 26'sh000_0014
    };

endpackage
